// ---- core/mlp_regs.vh ----
// register map, field positions, reset values and timing for the load protection stages
`ifndef MLP_REGS_VH
`define MLP_REGS_VH

// byte addresses: stage s at s*0x20, counter clear word after the three stages
`define MLP_OFS_CTRL 3'h0
`define MLP_OFS_PICK 3'h1
`define MLP_OFS_DLY 3'h2
`define MLP_OFS_STAT 3'h3
`define MLP_OFS_ALM_LO 3'h4
`define MLP_OFS_ALM_HI 3'h5
`define MLP_OFS_TRP_LO 3'h6
`define MLP_OFS_TRP_HI 3'h7
`define MLP_OFS_CLR 8'h60

// control word fields
`define MLP_B_FN_EN 0
`define MLP_B_EXTERNALLY_BLOCKED_FC 1
`define MLP_B_BLO_TC 2
`define MLP_B_EXTERNALLY_BLOCKED_TC_FC 3
`define MLP_B_MODE_ALL 4
`define MLP_B_MS_SEL 5
`define MLP_B_USE 8

// reset values
`define MLP_CTRL_RST_USE 9'h100
`define MLP_CTRL_RST_NOUSE 9'h000
`define MLP_UL_PICK_RST 11'h032
`define MLP_UL_DLY_RST 14'h0064
`define MLP_JAM_PICK_RST 11'h3E8
`define MLP_JAM_DLY_RST 14'h0014

// setting ranges, pickup in 0.01 rated current, delay in 0.1 s
`define MLP_UL_PICK_MIN 11'h005
`define MLP_UL_PICK_MAX 11'h05A
`define MLP_JAM_PICK_MIN 11'h064
`define MLP_JAM_PICK_MAX 11'h4B0
`define MLP_UL_DLY_MIN 14'h0004
`define MLP_JAM_DLY_MIN 14'h0000
`define MLP_DLY_MAX 14'h2EE0

// drop-out ratio of the undercurrent stage in percent
`define MLP_PCT_FULL 24'h000064
`define MLP_PCT_DROP 24'h000067

// counter ceiling
`define MLP_CNT_MAX 37'h174876E7FF

// delay resolution and clock period
`define MLP_TICK_NS 100000000
`define MLP_CLK_NS 50
`define MLP_TICK_CYCLES 21'h1E8480

`endif

// ---- core/mlp_stage.v ----
// one protection stage: pickup, delay timer, blocking and event counters
`timescale 1ns/1ps
`include "mlp_regs.vh"

module mlp_stage #(
	parameter IS_JAM = 1
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	input wire tick,
	// phase currents c,b,a packed, 0.01 rated current each
	input wire [47:0] cur,
	// settings
	input wire used,
	input wire fn_en,
	input wire externally_blocked_fc,
	input wire blo_tc,
	input wire externally_blocked_tc_fc,
	input wire mode_all,
	input wire [10:0] pickup,
	input wire [13:0] delay,
	// blocking sources
	input wire ext1,
	input wire ext2,
	input wire ext_tc,
	input wire ms_blk,
	// counter clears
	input wire clr_alm,
	input wire clr_trp,
	// status
	output reg active,
	output reg ext_blocked,
	output reg tc_perm_blk,
	output reg tc_ext_blk,
	output reg alarm,
	output reg trip,
	output reg trip_command,
	output reg [36:0] alarm_count,
	output reg [36:0] trip_count
);

	wire [2:0] over;
	wire [2:0] below;
	wire [2:0] held;
	reg [13:0] tmr;

	// per phase compares, undercurrent drop-out at 103 percent of pickup
	genvar p;
	generate
		for (p = 0; p < 3; p = p + 1) begin : g_ph
			wire [23:0] c = {8'h00, cur[16*p+15:16*p]};
			wire [23:0] pk = {13'h0000, pickup};
			assign over[p] = c > pk;
			assign below[p] = c < pk;
			assign held[p] = c * `MLP_PCT_FULL < pk * `MLP_PCT_DROP;
		end
	endgenerate

	// pickup with mode and hysteresis
	wire ul_pick = mode_all ? &below : |below;
	wire ul_hold = mode_all ? &held : |held;
	wire pick = IS_JAM ? |over : (alarm ? ul_hold : ul_pick);
	wire ext_blk_now = externally_blocked_fc & (ext1 | ext2);
	wire blocked = ~(used & fn_en) | ext_blk_now | ms_blk;
	wire tc_ext_now = externally_blocked_tc_fc & ext_tc;
	wire next_alarm = pick & ~blocked;
	wire tmr_done = tmr >= delay;
	wire next_trip = next_alarm & tmr_done;
	wire next_tc = next_trip & ~blo_tc & ~tc_ext_now;
	wire rise_alm = next_alarm & ~alarm;
	wire rise_tc = next_tc & ~trip_command;

	// status, timer and counters
	always @(posedge aclk) begin
		if (!aresetn) begin
			active <= 1'b0;
			ext_blocked <= 1'b0;
			tc_perm_blk <= 1'b0;
			tc_ext_blk <= 1'b0;
			alarm <= 1'b0;
			trip <= 1'b0;
			trip_command <= 1'b0;
			tmr <= 14'h0000;
			alarm_count <= 37'h0000000000;
			trip_count <= 37'h0000000000;
		end else begin
			active <= used & fn_en;
			ext_blocked <= ext_blk_now | ms_blk;
			tc_perm_blk <= blo_tc;
			tc_ext_blk <= tc_ext_now;
			alarm <= next_alarm;
			trip <= next_trip;
			trip_command <= next_tc;
			// timer restarts whenever pickup drops or stage blocks
			if (next_alarm & alarm) begin
				if (tick & ~tmr_done)
					tmr <= tmr + 14'h0001;
			end else begin
				tmr <= 14'h0000;
			end
			// a clear in the cycle of a new event keeps that event
			if (clr_alm)
				alarm_count <= {36'h000000000, rise_alm};
			else if (rise_alm & (alarm_count != `MLP_CNT_MAX))
				alarm_count <= alarm_count + 37'h0000000001;
			if (clr_trp)
				trip_count <= {36'h000000000, rise_tc};
			else if (rise_tc & (trip_count != `MLP_CNT_MAX))
				trip_count <= trip_count + 37'h0000000001;
		end
	end

endmodule // mlp_stage

// ---- core/mlp_top.v ----
// motor load protection: undercurrent stage, two jam stages, axi4-lite registers
`timescale 1ns/1ps
`include "mlp_regs.vh"

module mlp_top #(
	parameter [20:0] TICK_CYCLES = `MLP_TICK_CYCLES
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// measured phase currents, 0.01 rated current
	input wire [15:0] phase_a_current,
	input wire [15:0] phase_b_current,
	input wire [15:0] phase_c_current,
	// blocking inputs, bit 0 undercurrent, bits 1-2 jam
	input wire [2:0] ext_block_one_in,
	input wire [2:0] ext_block_two_in,
	input wire [2:0] ext_trip_cmd_block_in,
	input wire motor_start_jam_block_signal,
	input wire motor_start_alt_block_in,
	// stage status, same bit order
	output wire [2:0] stage_active,
	output wire [2:0] externally_blocked,
	output wire [2:0] trip_cmd_perm_blocked,
	output wire [2:0] trip_cmd_ext_blocked,
	output wire [2:0] alarm,
	output wire [2:0] trip,
	output wire [2:0] trip_command
);

	reg [8:0] ctrl [0:2];
	reg [10:0] pick [0:2];
	reg [13:0] dly [0:2];
	wire [36:0] alm_cnt [0:2];
	wire [36:0] trp_cnt [0:2];
	reg [2:0] clr_alm;
	reg [2:0] clr_trp;
	reg [20:0] tick_cnt;
	reg tick;
	reg aw_got;
	reg w_got;
	reg [7:0] awa;
	reg [31:0] wd;
	reg [3:0] ws;
	integer i;

	// delay resolution tick, one pulse per 0.1 s
	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= 21'h000000;
			tick <= 1'b0;
		end else if (tick_cnt == TICK_CYCLES - 21'h000001) begin
			tick_cnt <= 21'h000000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 21'h000001;
			tick <= 1'b0;
		end
	end

	// aligned and mapped address
	function addr_ok;
		input [7:0] a;
		begin
			addr_ok = (a[1:0] == 2'h0) && (a <= `MLP_OFS_CLR);
		end
	endfunction

	// status word of one stage
	function [31:0] stat_word;
		input [1:0] s;
		begin
			stat_word = {25'h0000000, trip_command[s], trip[s], alarm[s],
				trip_cmd_ext_blocked[s], trip_cmd_perm_blocked[s],
				externally_blocked[s], stage_active[s]};
		end
	endfunction

	// register read mux, shared by reads and write merges
	function [31:0] word_at;
		input [7:0] a;
		reg [1:0] s;
		begin
			word_at = 32'h00000000;
			s = a[6:5];
			if (addr_ok(a) && (a < `MLP_OFS_CLR)) begin
				case (a[4:2])
					`MLP_OFS_CTRL: word_at = {23'h000000, ctrl[s]};
					`MLP_OFS_PICK: word_at = {21'h000000, pick[s]};
					`MLP_OFS_DLY: word_at = {18'h00000, dly[s]};
					`MLP_OFS_STAT: word_at = stat_word(s);
					`MLP_OFS_ALM_LO: word_at = alm_cnt[s][31:0];
					`MLP_OFS_ALM_HI: word_at = {27'h0000000, alm_cnt[s][36:32]};
					`MLP_OFS_TRP_LO: word_at = trp_cnt[s][31:0];
					`MLP_OFS_TRP_HI: word_at = {27'h0000000, trp_cnt[s][36:32]};
					default: word_at = 32'h00000000;
				endcase
			end
		end
	endfunction

	// bound a setting to its range
	function [13:0] clamp;
		input [13:0] v;
		input [13:0] lo;
		input [13:0] hi;
		begin
			if (v < lo)
				clamp = lo;
			else if (v > hi)
				clamp = hi;
			else
				clamp = v;
		end
	endfunction

	// byte-lane merge of pending write
	wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
	wire [31:0] merged = (word_at(awa) & ~wmask) | (wd & wmask);
	wire [1:0] wsel = awa[6:5];
	wire wsel_ul = (wsel == 2'h0);
	wire [13:0] pick_lo = wsel_ul ? {3'h0, `MLP_UL_PICK_MIN} : {3'h0, `MLP_JAM_PICK_MIN};
	wire [13:0] pick_hi = wsel_ul ? {3'h0, `MLP_UL_PICK_MAX} : {3'h0, `MLP_JAM_PICK_MAX};
	wire [13:0] dly_lo = wsel_ul ? `MLP_UL_DLY_MIN : `MLP_JAM_DLY_MIN;
	wire [13:0] pick_new = clamp({3'h0, merged[10:0]}, pick_lo, pick_hi);
	wire [13:0] dly_new = clamp(merged[13:0], dly_lo, `MLP_DLY_MAX);
	wire do_write = aw_got & w_got;

	// handshakes
	assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	// write channel: address and data in either order, response after both
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awa <= 8'h00;
			wd <= 32'h00000000;
			ws <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_got <= 1'b1;
				awa <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_got <= 1'b1;
				wd <= s_axi_wdata;
				ws <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_ok(awa) ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// settings and counter clear pulses
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < 3; i = i + 1) begin
				ctrl[i] <= (i == 1) ? `MLP_CTRL_RST_USE : `MLP_CTRL_RST_NOUSE;
				pick[i] <= (i == 0) ? `MLP_UL_PICK_RST : `MLP_JAM_PICK_RST;
				dly[i] <= (i == 0) ? `MLP_UL_DLY_RST : `MLP_JAM_DLY_RST;
			end
			clr_alm <= 3'h0;
			clr_trp <= 3'h0;
		end else begin
			clr_alm <= 3'h0;
			clr_trp <= 3'h0;
			if (do_write && addr_ok(awa)) begin
				if (awa == `MLP_OFS_CLR) begin
					clr_alm <= merged[2:0];
					clr_trp <= merged[6:4];
				end else begin
					case (awa[4:2])
						`MLP_OFS_CTRL: begin
							ctrl[wsel] <= merged[8:0];
						end
						`MLP_OFS_PICK: begin
							pick[wsel] <= pick_new[10:0];
						end
						`MLP_OFS_DLY: begin
							dly[wsel] <= dly_new;
						end
						default: begin
							ctrl[wsel] <= ctrl[wsel];
						end
					endcase
				end
			end
		end
	end

	// read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= word_at(s_axi_araddr);
			s_axi_rresp <= addr_ok(s_axi_araddr) ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// the three stages; undercurrent has no planning setting and is always in use
	wire [47:0] cur_bus = {phase_c_current, phase_b_current, phase_a_current};
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_stage
			wire [8:0] c = ctrl[g];
			wire used = (g == 0) ? 1'b1 : c[`MLP_B_USE];
			// start blocking source, motor-start jam signal by default
			wire ms = c[`MLP_B_MS_SEL] ? motor_start_alt_block_in
				: motor_start_jam_block_signal;
			mlp_stage #(
				.IS_JAM((g == 0) ? 0 : 1)
			) u_stage (
				.aclk(aclk),
				.aresetn(aresetn),
				.tick(tick),
				.cur(cur_bus),
				.used(used),
				.fn_en(c[`MLP_B_FN_EN]),
				.externally_blocked_fc(c[`MLP_B_EXTERNALLY_BLOCKED_FC]),
				.blo_tc(c[`MLP_B_BLO_TC]),
				.externally_blocked_tc_fc(c[`MLP_B_EXTERNALLY_BLOCKED_TC_FC]),
				.mode_all(c[`MLP_B_MODE_ALL]),
				.pickup(pick[g]),
				.delay(dly[g]),
				.ext1(ext_block_one_in[g]),
				.ext2(ext_block_two_in[g]),
				.ext_tc(ext_trip_cmd_block_in[g]),
				.ms_blk(ms),
				.clr_alm(clr_alm[g]),
				.clr_trp(clr_trp[g]),
				.active(stage_active[g]),
				.ext_blocked(externally_blocked[g]),
				.tc_perm_blk(trip_cmd_perm_blocked[g]),
				.tc_ext_blk(trip_cmd_ext_blocked[g]),
				.alarm(alarm[g]),
				.trip(trip[g]),
				.trip_command(trip_command[g]),
				.alarm_count(alm_cnt[g]),
				.trip_count(trp_cnt[g])
			);
		end
	endgenerate

endmodule // mlp_top

// ---- verif/mlp_sva.sv ----
// concurrent checks on the load protection top ports
`timescale 1ns/1ps
module mlp_sva #(
	parameter [20:0] TICK_CYCLES = 21'h00000A
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// bus handshakes
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_arready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// stage status
	input wire [2:0] stage_active,
	input wire [2:0] externally_blocked,
	input wire [2:0] trip_cmd_perm_blocked,
	input wire [2:0] trip_cmd_ext_blocked,
	input wire [2:0] alarm,
	input wire [2:0] trip,
	input wire [2:0] trip_command
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	reg [2:0] off_q;
	reg [2:0] blk_q;
	// previous cycle inactive or blocked
	always @(posedge aclk) begin
		off_q <= ~stage_active;
		blk_q <= externally_blocked;
	end
	sequence s_bwait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	sequence s_rwait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	property p_tc_trip;
		(trip_command & ~trip) == 3'h0;
	endproperty
	a_tc_trip: assert property (p_tc_trip) else $error("trip command without trip");
	property p_trip_alarm;
		(trip & ~alarm) == 3'h0;
	endproperty
	a_trip_alarm: assert property (p_trip_alarm) else $error("trip without alarm");
	property p_perm;
		(trip_cmd_perm_blocked & trip_command) == 3'h0;
	endproperty
	a_perm: assert property (p_perm) else $error("perm block leaks command");
	property p_ext_tc;
		(trip_cmd_ext_blocked & trip_command) == 3'h0;
	endproperty
	a_ext_tc: assert property (p_ext_tc) else $error("ext block leaks command");
	property p_tc_follow;
		(trip & ~trip_cmd_perm_blocked & ~trip_cmd_ext_blocked & ~trip_command) == 3'h0;
	endproperty
	a_tc_follow: assert property (p_tc_follow) else $error("unblocked trip lacks command");
	property p_off;
		(off_q & ~stage_active & (alarm | trip | trip_command)) == 3'h0;
	endproperty
	a_off: assert property (p_off) else $error("inactive stage outputs set");
	property p_blk;
		(blk_q & externally_blocked & (alarm | trip | trip_command)) == 3'h0;
	endproperty
	a_blk: assert property (p_blk) else $error("blocked stage outputs set");
	property p_bhold;
		s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold;
		s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_busy;
		(s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready);
	endproperty
	a_busy: assert property (p_busy) else $error("ready while answer pending");
endmodule // mlp_sva

bind mlp_top mlp_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);

// ---- verif/tb.sv ----
// self-checking bench for the load protection top
`timescale 1ns/1ps
module tb;
	localparam int TK = 10;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	logic [15:0] phase_a_current = 0, phase_b_current = 0, phase_c_current = 0;
	logic [2:0] ext_block_one_in = 0, ext_block_two_in = 0, ext_trip_cmd_block_in = 0;
	logic motor_start_jam_block_signal = 0, motor_start_alt_block_in = 0;
	wire [2:0] stage_active, externally_blocked, trip_cmd_perm_blocked;
	wire [2:0] trip_cmd_ext_blocked, alarm, trip, trip_command;
	int errors = 0;
	int check_count = 0;
	mlp_top #(.TICK_CYCLES(21'h00000A)) DUT (.*);
	// 20 mhz clock
	initial begin
		forever #25 aclk = ~aclk;
	end
	task automatic chk(input logic [36:0] g, input logic [36:0] e, input string m);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, g, e);
		end
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic tmo;
		errors++;
		$display("CHECK FAILED t=%0t timeout", $time);
		conclude();
	endtask
	// let n edges pass, then settle mid-cycle where outputs are stable
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask
	// write: both channels offered together, held until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit ta, tw, tv, done;
		done = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (int n = 0; n < 40 && !done; n++) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tv = s_axi_bvalid;
			if (tv) chk(s_axi_bresp, er, "bresp");
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (tv) s_axi_bready <= 0;
			done = tv;
		end
		if (!done) tmo();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ta, done;
		done = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (int n = 0; n < 40 && !done; n++) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			done = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 0;
			if (done) s_axi_rready <= 0;
		end
		if (!done) tmo();
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e, "rdata");
		chk(r, 2'h0, "rresp");
	endtask
	// cycles until trip of stage s
	task automatic tcount(input int s, output int n);
		n = 0;
		while (trip[s] !== 1'b1) begin
			@(negedge aclk);
			n++;
			if (n > 20000) tmo();
		end
	endtask
	// jam one with control c and blocking inputs in,
	// expect {alarm, command, ext blocked, perm blocked, ext cmd blocked}
	task automatic blk(input logic [8:0] c, input logic [4:0] in, input logic [4:0] e);
		wr(8'h20, 32'h00000101 | c, 2'h0);
		ext_block_one_in <= {1'b0, in[0], 1'b0};
		ext_block_two_in <= {1'b0, in[1], 1'b0};
		ext_trip_cmd_block_in <= {1'b0, in[2], 1'b0};
		motor_start_jam_block_signal <= in[3];
		motor_start_alt_block_in <= in[4];
		cyc(3);
		chk({alarm[1], trip_command[1], externally_blocked[1], trip_cmd_perm_blocked[1],
			trip_cmd_ext_blocked[1]}, e, "block");
	endtask
	function automatic logic [31:0] rv(input int s, input int o);
		case (o)
			0: rv = (s == 1) ? 32'h00000100 : 32'h00000000;
			4: rv = (s == 0) ? 32'h00000032 : 32'h000003E8;
			default: rv = (s == 0) ? 32'h00000064 : 32'h00000014;
		endcase
	endfunction
	initial begin
		int p;
		int d;
		int n;
		logic [31:0] x;
		logic [1:0] r;
		p = $urandom(32'hC54E3D8D);
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		// reset values, unmapped places, clamping
		for (int s = 0; s < 3; s++)
			for (int o = 0; o < 12; o += 4)
				rc(8'(s * 32 + o), rv(s, o));
		cyc(0);
		chk(stage_active, 3'h0, "active");
		rd(8'h64, x, r);
		chk({x, r}, 34'h2, "unmapped");
		wr(8'hF0, 32'h1, 2'h2);
		wr(8'h24, 32'h0, 2'h0);
		rc(8'h24, 32'h00000064);
		wr(8'h08, 32'h0, 2'h0);
		rc(8'h08, 32'h00000004);
		// one byte lane only: low byte replaced, upper bits kept
		s_axi_wstrb <= 4'h1;
		wr(8'h44, 32'hFFFFFF20, 2'h0);
		s_axi_wstrb <= 4'hF;
		rc(8'h44, 32'h00000320);
		$display("regs done");
		// jam one: strict pickup, delay, counters
		p = 100 + $urandom % 1101;
		d = 2 + $urandom % 3;
		wr(8'h24, p, 2'h0);
		wr(8'h28, d, 2'h0);
		wr(8'h20, 32'h00000101, 2'h0);
		cyc(0);
		chk(stage_active, 3'h2, "active");
		@(posedge aclk);
		phase_b_current <= 16'(p);
		cyc(4);
		chk(alarm, 3'h0, "equal");
		@(posedge aclk);
		phase_b_current <= 16'(p + 1);
		cyc(1);
		chk(alarm, 3'h2, "alarm");
		tcount(1, n);
		chk(n >= (d - 1) * TK + 2 && n <= d * TK + 1, 1, "delay");
		chk(trip_command, 3'h2, "cmd");
		rc(8'h2C, 32'h00000071);
		rc(8'h30, 32'h00000001);
		rc(8'h38, 32'h00000001);
		// short dip: outputs fall, timer starts over
		phase_b_current <= 16'h0000;
		cyc(3);
		chk({alarm, trip, trip_command}, 9'h000, "fall");
		@(posedge aclk);
		phase_b_current <= 16'(p + 1);
		tcount(1, n);
		chk(n >= (d - 1) * TK + 4 && n <= d * TK + 3, 1, "restart");
		rc(8'h30, 32'h00000002);
		wr(8'h60, 32'h00000022, 2'h0);
		rc(8'h30, 32'h00000000);
		rc(8'h38, 32'h00000000);
		$display("jam done");
		// blocking table on jam one, no delay
		wr(8'h28, 32'h0, 2'h0);
		blk(9'h000, 5'h01, 5'h18);
		blk(9'h002, 5'h01, 5'h04);
		blk(9'h002, 5'h02, 5'h04);
		blk(9'h000, 5'h08, 5'h04);
		blk(9'h020, 5'h08, 5'h18);
		blk(9'h020, 5'h10, 5'h04);
		blk(9'h004, 5'h00, 5'h12);
		blk(9'h008, 5'h04, 5'h11);
		blk(9'h000, 5'h04, 5'h18);
		wr(8'h20, 32'h00000100, 2'h0);
		cyc(0);
		chk({alarm, trip, trip_command}, 9'h000, "disabled");
		// jam two only counts once planned in use
		@(posedge aclk);
		phase_c_current <= 16'h044C;
		wr(8'h40, 32'h00000001, 2'h0);
		cyc(3);
		chk(alarm[2], 1'b0, "unused");
		wr(8'h40, 32'h00000101, 2'h0);
		cyc(0);
		chk(alarm[2], 1'b1, "used");
		wr(8'h40, 32'h0, 2'h0);
		$display("block done");
		// undercurrent: delay, drop-out ratio, phase mode
		phase_a_current <= 16'h0064;
		phase_b_current <= 16'h0064;
		phase_c_current <= 16'h0064;
		p = 5 + $urandom % 86;
		d = 4 + $urandom % 2;
		wr(8'h04, p, 2'h0);
		wr(8'h08, d, 2'h0);
		wr(8'h00, 32'h00000001, 2'h0);
		phase_a_current <= 16'(p - 1);
		tcount(0, n);
		chk(n >= (d - 1) * TK + 4 && n <= d * TK + 3, 1, "ul delay");
		chk(trip_command[0], 1'b1, "ul cmd");
		@(posedge aclk);
		phase_a_current <= 16'((103 * p - 1) / 100);
		cyc(4);
		chk(alarm[0], 1'b1, "hold");
		@(posedge aclk);
		phase_a_current <= 16'((103 * p + 99) / 100);
		cyc(4);
		chk(alarm[0], 1'b0, "drop");
		wr(8'h00, 32'h00000011, 2'h0);
		phase_a_current <= 16'(p - 1);
		cyc(4);
		chk(alarm[0], 1'b0, "one of all");
		@(posedge aclk);
		phase_b_current <= 16'(p - 1);
		phase_c_current <= 16'(p - 1);
		cyc(4);
		chk(alarm[0], 1'b1, "all");
		$display("undercurrent done");
		conclude();
	end
	// overall watchdog
	initial begin
		repeat (100000) @(posedge aclk);
		tmo();
	end
endmodule // tb
